// [rtl/pacp_port.sv]
`timescale 1ns/1ps
`default_nettype none
module pacp_port
  import pacp_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYCLES_DEF,
  parameter int IMAGE_BYTES = IMAGE_BYTES_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_config_request_n,
  input wire pacp_host_s i_host,
  input wire logic i_user_startup_clock,
  input wire logic i_usr_clk_opt,
  input wire logic i_byte_error,
  input wire logic i_jtag_config_req,
  input wire logic i_jtag_config_done,
  input wire logic i_decompress_opt,
  output logic o_config_status_n_o,
  output logic o_config_status_n_oe,
  output logic o_config_complete,
  output logic o_data_msb_status_o,
  output logic o_data_msb_status_oe,
  output logic o_ready_busy_n,
  output pacp_byte_s o_byte,
  output logic o_startup_clk_enable,
  output logic o_user_mode,
  output logic o_user_io_enable,
  output logic o_io_tristate,
  output logic o_decompress_ok
);
  localparam int BW = $clog2(IMAGE_BYTES + 1);

  if (POR_CYCLES < 1 || POR_CYCLES >= (1 << TW)) begin : g_chk_por
    $error("POR_CYCLES out of range");
  end
  if (IMAGE_BYTES < 1) begin : g_chk_img
    $error("IMAGE_BYTES must be positive");
  end

  pacp_state_e state_q;
  logic ws_prev_q;
  logic usr_prev_q;
  logic [BW-1:0] bytes_q;
  logic selected;
  logic ws_rise;
  logic capture;
  logic last_byte;
  logic usr_rise;
  logic t_load;
  logic [TW-1:0] t_value;
  logic t_done;
  logic u_load;
  logic u_done;
  logic to_reset;

  // **************************************************
  // Strobe edges and byte capture
  // **************************************************
  assign selected = i_host.chip_select && !i_host.chip_select_low;
  assign ws_rise = !ws_prev_q && i_host.write_strobe_n;
  assign capture = (state_q == PACP_CFG) && ws_rise && selected;
  assign last_byte = (bytes_q == BW'(IMAGE_BYTES - 1));
  assign usr_rise = !usr_prev_q && i_user_startup_clock;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ws_prev_q <= 1'b1;
      usr_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      ws_prev_q <= i_host.write_strobe_n;
      usr_prev_q <= i_user_startup_clock;
    end
  end

  // Busy is one clock wide, 20 ns, from the cycle the rising edge is seen.
  assign o_ready_busy_n = !capture;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_byte <= '0;
    end else if (i_clk_en) begin
      o_byte.valid <= capture;
      if (capture) begin
        o_byte.data <= i_host.data;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bytes_q <= '0;
    end else if (i_clk_en) begin
      if (state_q != PACP_CFG) begin
        bytes_q <= '0;
      end else if (capture) begin
        bytes_q <= bytes_q + BW'(1);
      end
    end
  end

  // **************************************************
  // Status read-back on the top data pin
  // **************************************************
  // Only the device in active configuration drives, so chained parts never fight.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_data_msb_status_oe <= 1'b0;
      o_data_msb_status_o <= 1'b1;
    end else if (i_clk_en) begin
      o_data_msb_status_oe <= (state_q == PACP_CFG) && !i_host.read_strobe_n;
      o_data_msb_status_o <= o_ready_busy_n;
    end
  end

  // **************************************************
  // Configuration sequence
  // **************************************************
  assign to_reset = !i_config_request_n || ((state_q == PACP_CFG) && i_byte_error);

  always_comb begin
    t_load = 1'b0;
    t_value = STATUS_CYC;
    u_load = 1'b0;
    if (i_jtag_config_req && state_q != PACP_JTAG) begin
      t_load = 1'b0;
    end else if (state_q == PACP_JTAG) begin
      t_load = 1'b1;
      t_value = i_jtag_config_done ? CD2UM_CYC : STATUS_CYC;
      u_load = 1'b1;
    end else if (to_reset) begin
      t_load = 1'b1;
    end else if (state_q == PACP_CFG && capture && last_byte) begin
      t_load = 1'b1;
      t_value = i_usr_clk_opt ? CD2CU_CYC : CD2UM_CYC;
      u_load = 1'b1;
    end
  end

  pacp_timer #(
    .RESET_VAL(TW'(POR_CYCLES))
  ) u_main_timer (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_load(t_load),
    .i_value(t_value),
    .i_step(1'b1),
    .o_done(t_done)
  );

  // Counts user clock periods once that clock is enabled.
  pacp_timer #(
    .RESET_VAL(USR_CYC)
  ) u_usr_timer (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_load(u_load),
    .i_value(USR_CYC),
    .i_step(o_startup_clk_enable && usr_rise),
    .o_done(u_done)
  );

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= PACP_POR;
    end else if (i_clk_en) begin
      if (i_jtag_config_req && state_q != PACP_JTAG) begin
        state_q <= PACP_JTAG;
      end else if (state_q == PACP_JTAG) begin
        if (i_jtag_config_done) begin
          state_q <= PACP_START;
        end else if (!i_jtag_config_req) begin
          state_q <= PACP_RESET;
        end
      end else if (to_reset && state_q != PACP_POR) begin
        state_q <= PACP_RESET;
      end else begin
        unique case (state_q)
          PACP_POR: begin
            if (t_done) begin
              state_q <= i_config_request_n ? PACP_CFG : PACP_RESET;
            end
          end
          PACP_RESET: begin
            if (t_done) begin
              state_q <= PACP_CFG;
            end
          end
          PACP_CFG: begin
            if (capture && last_byte) begin
              state_q <= PACP_START;
            end
          end
          PACP_START: begin
            if (t_done && (!i_usr_clk_opt || u_done)) begin
              state_q <= PACP_USER;
            end
          end
          PACP_USER: begin
            state_q <= PACP_USER;
          end
          default: begin
            state_q <= PACP_RESET;
          end
        endcase
      end
    end
  end

  // **************************************************
  // Pin and mode outputs
  // **************************************************
  assign o_config_status_n_o = 1'b0;
  assign o_config_status_n_oe = (state_q == PACP_POR) || (state_q == PACP_RESET);
  assign o_config_complete = (state_q == PACP_START) || (state_q == PACP_USER);
  assign o_startup_clk_enable = (state_q == PACP_START) && i_usr_clk_opt && t_done;
  assign o_user_mode = (state_q == PACP_USER);
  assign o_user_io_enable = (state_q == PACP_USER);
  assign o_io_tristate = (state_q == PACP_JTAG);
  assign o_decompress_ok = i_decompress_opt && (state_q != PACP_JTAG);

  // **************************************************
  // Assertions
  // **************************************************
  sequence s_req_fall;
    i_clk_en && !i_config_request_n && !i_jtag_config_req && state_q != PACP_JTAG;
  endsequence

  sequence s_ws_rise;
    i_clk_en && capture;
  endsequence

  property p_user_high;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_user_mode |-> o_config_complete && !o_config_status_n_oe;
  endproperty
  a_user_high: assert property (p_user_high) else $error("user mode pins not high");

  property p_por_low;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (state_q == PACP_POR) |-> o_config_status_n_oe;
  endproperty
  a_por_low: assert property (p_por_low) else $error("status released in POR");

  property p_cd_low;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (state_q inside {PACP_POR, PACP_RESET, PACP_CFG}) |-> !o_config_complete;
  endproperty
  a_cd_low: assert property (p_cd_low) else $error("complete high early");

  property p_req_cd;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    s_req_fall |=> !o_config_complete;
  endproperty
  a_req_cd: assert property (p_req_cd) else $error("complete not low after request");

  property p_req_st;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    s_req_fall |=> o_config_status_n_oe;
  endproperty
  a_req_st: assert property (p_req_st) else $error("status not low after request");

  property p_busy;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    s_ws_rise |-> !o_ready_busy_n ##1 (!i_clk_en || o_ready_busy_n);
  endproperty
  a_busy: assert property (p_busy) else $error("busy pulse wrong");

  property p_capture;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    s_ws_rise |=> o_byte.valid && o_byte.data == $past(i_host.data);
  endproperty
  a_capture: assert property (p_capture) else $error("byte not captured");

  property p_rd;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && state_q == PACP_CFG && !i_host.read_strobe_n |=>
      o_data_msb_status_oe && o_data_msb_status_o == $past(o_ready_busy_n);
  endproperty
  a_rd: assert property (p_rd) else $error("status not shown on read");

  property p_tri;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    $past(state_q) != PACP_CFG && state_q != PACP_CFG |-> !o_data_msb_status_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("data driven outside config");

  property p_jtag;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    i_clk_en && i_jtag_config_req && !i_jtag_config_done |=>
      o_io_tristate && !o_decompress_ok && !o_config_status_n_oe;
  endproperty
  a_jtag: assert property (p_jtag) else $error("JTAG did not take over");

  property p_release;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    $fell(o_config_status_n_oe) |-> $past(t_done) && $past(i_config_request_n);
  endproperty
  a_release: assert property (p_release) else $error("status released early");

  property p_user_io;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    o_user_io_enable |-> o_config_complete && !o_data_msb_status_oe;
  endproperty
  a_user_io: assert property (p_user_io) else $error("user I/O before done");
endmodule
`default_nettype wire

// [include/pacp_pkg.sv]
// Notes on behaviour
// - User mode keeps pins high; request low restarts.
// - Status held low through power-on delay.
// - Complete low until configuration finishes.
// - Top data pin: data in, status out.
// - After configuration port pins become user I/O.
// - Request fall drives complete low within 800 ns.
// - Request fall pulls status low within 800 ns.
// - Status low 10 to 100 us.
// - Busy within 20 ns, lasting 7 to 45 ns.
// - Read strobe shows ready state within 20 ns.
// - Oscillator start-up takes 20 to 100 us.
// - User clock enabled after 40 ns, 299 periods.
// - JTAG request aborts and overrides this port.
// - No decompression under JTAG configuration.
// - User I/O tristated during JTAG configuration.
// - Data pins tristated outside active configuration.
package pacp_pkg;

  localparam int CLK_NS = 20;
  localparam int TW = 17;

  // **************************************************
  // Timing figures and their cycle counts
  // **************************************************
  localparam int CF2CD_MAX_NS = 800;
  localparam int STATUS_MIN_US = 10;
  localparam int CD2UM_MIN_US = 20;
  localparam int CD2CU_MIN_NS = 40;
  localparam int USR_PERIODS = 299;
  localparam int POR_CYCLES_DEF = 5000;
  localparam int IMAGE_BYTES_DEF = 1024;

  localparam logic [TW-1:0] STATUS_CYC = TW'((STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] CD2UM_CYC = TW'((CD2UM_MIN_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] CD2CU_CYC = TW'((CD2CU_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] USR_CYC = TW'(USR_PERIODS);
  localparam int CF2CD_CYC = CF2CD_MAX_NS / CLK_NS;

  // **************************************************
  // States and carriers
  // **************************************************
  typedef enum logic [2:0] {
    PACP_POR = 3'h0,
    PACP_RESET = 3'h1,
    PACP_CFG = 3'h3,
    PACP_START = 3'h2,
    PACP_USER = 3'h6,
    PACP_JTAG = 3'h7
  } pacp_state_e;

  typedef struct packed {
    logic chip_select_low;
    logic chip_select;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [7:0] data;
  } pacp_host_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pacp_byte_s;

endpackage

// [rtl/pacp_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module pacp_timer
  import pacp_pkg::*;
#(
  parameter logic [TW-1:0] RESET_VAL = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_load,
  input wire logic [TW-1:0] i_value,
  input wire logic i_step,
  output logic o_done
);
  logic [TW-1:0] cnt_q;

  // Load wins over a step so that a restart always runs the full count.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= RESET_VAL;
    end else if (i_clk_en) begin
      if (i_load) begin
        cnt_q <= i_value;
      end else if (i_step && cnt_q != '0) begin
        cnt_q <= cnt_q - TW'(1);
      end
    end
  end

  assign o_done = (cnt_q == '0);
endmodule
`default_nettype wire

// [dv/pacp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pacp_host_model
  import pacp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_ready_busy_n,
  output var pacp_host_s o_host,
  output var logic o_config_request_n
);
  // **************************************************
  // Host microprocessor side of the port
  // **************************************************
  initial begin
    o_host = {1'b1, 1'b0, 1'b1, 1'b1, 8'h5a};
    o_config_request_n = 1'b1;
  end

  // The request stays low for 101 cycles, past the minimum pulse.
  task automatic reconfig();
    @(posedge i_sys_clk) o_config_request_n <= 1'b0;
    repeat (101) @(posedge i_sys_clk);
    o_config_request_n <= 1'b1;
  endtask

  // Selects frame the whole strobe and outlast its rise.
  task automatic write_byte(input logic [7:0] d, input logic sel);
    @(posedge i_sys_clk) o_host <= {~sel, sel, 1'b0, 1'b1, d};
    @(posedge i_sys_clk) o_host.write_strobe_n <= 1'b1;
    @(posedge i_sys_clk);
    for (int n = 0; n < 8 && i_ready_busy_n !== 1'b1; n++) begin
      @(posedge i_sys_clk);
    end
    // A cycle after ready passes before anything moves; the idle bus shows stale data inverted.
    @(posedge i_sys_clk) o_host <= {1'b1, 1'b0, 1'b1, 1'b1, ~d};
  endtask

  task automatic read_strobe(input logic v);
    @(posedge i_sys_clk) o_host.read_strobe_n <= v;
    repeat (2) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// [dv/tb_parallel_async_config_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_async_config_port;
  import pacp_pkg::*;
  localparam int NB = 4;
  logic sys_clk = 1'b0;
  logic reset_n, usr_clk, usr_opt, jtag_req, jtag_done, req_n;
  logic st_o, st_oe, complete, d7_o, d7_oe, rdy_n, ck_en, user_mode, uio, tri_io, dec_ok;
  logic clk_en, byte_err, dec_opt;
  pacp_host_s host;
  pacp_byte_s byte_out;
  int failures = 0;
  int comparisons = 0;
  int nbusy = 0;
  logic [7:0] seen[$];
  logic [7:0] want[$];

  // **************************************************
  // Clock, design, host and monitors
  // **************************************************
  always #10 sys_clk = ~sys_clk;

  pacp_port #(.POR_CYCLES(20), .IMAGE_BYTES(NB)) pacp_port_i (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_clk_en(clk_en),
    .i_config_request_n(req_n), .i_host(host), .i_user_startup_clock(usr_clk),
    .i_usr_clk_opt(usr_opt), .i_byte_error(byte_err), .i_jtag_config_req(jtag_req),
    .i_jtag_config_done(jtag_done), .i_decompress_opt(dec_opt),
    .o_config_status_n_o(st_o), .o_config_status_n_oe(st_oe),
    .o_config_complete(complete), .o_data_msb_status_o(d7_o),
    .o_data_msb_status_oe(d7_oe), .o_ready_busy_n(rdy_n), .o_byte(byte_out),
    .o_startup_clk_enable(ck_en), .o_user_mode(user_mode), .o_user_io_enable(uio),
    .o_io_tristate(tri_io), .o_decompress_ok(dec_ok));

  pacp_host_model host_i (.i_sys_clk(sys_clk), .i_ready_busy_n(rdy_n), .o_host(host),
    .o_config_request_n(req_n));

  always @(posedge sys_clk) begin
    if (byte_out.valid === 1'b1) seen.push_back(byte_out.data);
    if (rdy_n === 1'b0) nbusy++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // **************************************************
  // Scenario steps
  // **************************************************
  task automatic restart();
    fork
      host_i.reconfig();
      begin
        cyc(40);
        check(complete, 0, "complete after request");
        check(st_oe, 1, "status after request");
        check(st_o, 0, "status drive level");
      end
    join
    cyc(490);
    check(st_oe, 1, "status held low");
    host_i.read_strobe(1'b0);
    check(d7_oe, 0, "top data pin before config");
    host_i.read_strobe(1'b1);
    cyc(110);
    check(st_oe, 0, "status released");
    cyc(4400);
  endtask

  task automatic load(input int nb);
    logic [7:0] d;
    seen.delete();
    want.delete();
    nbusy = 0;
    host_i.write_byte(8'h3c, 1'b0);
    // A selected strobe while the clock enable is low must leave no trace.
    @(posedge sys_clk) clk_en <= 1'b0;
    host_i.write_byte(8'h96, 1'b1);
    @(posedge sys_clk) clk_en <= 1'b1;
    #1;
    check(seen.size(), 0, "frozen strobe ignored");
    for (int i = 0; i < nb; i++) begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      want.push_back(d);
      host_i.write_byte(d, 1'b1);
      if (i == 0) begin
        host_i.read_strobe(1'b0);
        check(d7_oe, 1, "top data pin driven");
        check(d7_o, 1, "ready on top data pin");
        host_i.read_strobe(1'b1);
      end
    end
    #1;
    check(seen.size(), nb, "bytes captured");
    check(nbusy, nb, "busy pulses");
    for (int i = 0; i < seen.size() && i < nb; i++) check(seen[i], want[i], "byte");
  endtask

  task automatic usr_rise(input int n);
    repeat (n) begin
      @(posedge sys_clk) usr_clk <= 1'b1;
      @(posedge sys_clk);
      @(posedge sys_clk) usr_clk <= 1'b0;
      @(posedge sys_clk);
    end
    #1;
  endtask

  initial begin
    reset_n = 1'b0;
    usr_clk = 1'b0;
    usr_opt = 1'b0;
    jtag_req = 1'b0;
    jtag_done = 1'b0;
    clk_en = 1'b1;
    byte_err = 1'b0;
    dec_opt = 1'b1;
    void'($urandom(6479));
    cyc(1);
    check(st_oe, 1, "status in reset");
    check(complete, 0, "complete in reset");
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    cyc(10);
    check(st_oe, 1, "status during power-on delay");
    $display("test reset done");
    restart();
    load(NB);
    cyc(1);
    check(complete, 1, "complete after last byte");
    cyc(985);
    check(user_mode, 0, "early user mode");
    cyc(20);
    check(user_mode, 1, "user mode");
    check(uio, 1, "port pins as user io");
    check({complete, st_oe}, 2'b10, "user mode pins");
    host_i.read_strobe(1'b0);
    check(d7_oe, 0, "top data pin in user mode");
    host_i.read_strobe(1'b1);
    $display("test oscillator start-up done");
    @(posedge sys_clk) usr_opt <= 1'b1;
    restart();
    load(NB);
    cyc(1);
    check(ck_en, 1, "user clock enabled");
    usr_rise(298);
    check(user_mode, 0, "user mode before 299 periods");
    usr_rise(1);
    cyc(2);
    check(user_mode, 1, "user mode after 299 periods");
    $display("test user clock start-up done");
    @(posedge sys_clk) usr_opt <= 1'b0;
    restart();
    load(2);
    @(posedge sys_clk) byte_err <= 1'b1;
    @(posedge sys_clk) byte_err <= 1'b0;
    cyc(2);
    check(st_oe, 1, "status after byte error");
    check(complete, 0, "complete after byte error");
    cyc(505);
    check(st_oe, 0, "status after error restart");
    check(dec_ok, 1, "decompression outside jtag");
    @(posedge sys_clk) dec_opt <= 1'b0;
    cyc(1);
    check(dec_ok, 0, "decompression option off");
    @(posedge sys_clk) dec_opt <= 1'b1;
    @(posedge sys_clk) jtag_req <= 1'b1;
    cyc(2);
    check(tri_io, 1, "io tristated");
    check(dec_ok, 0, "decompression blocked");
    check(complete, 0, "parallel load abandoned");
    host_i.write_byte(8'ha5, 1'b1);
    check(seen.size(), 2, "strobe ignored under jtag");
    @(posedge sys_clk) jtag_done <= 1'b1;
    @(posedge sys_clk) jtag_done <= 1'b0;
    jtag_req <= 1'b0;
    cyc(1010);
    check(user_mode, 1, "user mode after jtag load");
    $display("test jtag override done");
    test_done();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
